// ---- rtl/tac_abort_tracker.v ----
// Transmit abort cause tracker: sticky cause flags for master and slave
// roles, an APB register view, the stale FIFO flush and the abort level.
// Assumes the master and slave engines deliver one-cycle event pulses and
// levels synchronous to clock, and an APB master on the same clock.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "tac_defs.vh"

module tac_abort_tracker (
  input  wire                    clock,
  input  wire                    reset,
  // APB slave.
  input  wire                    psel,
  input  wire                    penable,
  input  wire                    pwrite,
  input  wire [31:0]             paddr,
  input  wire [31:0]             pwdata,
  output wire                    pready,
  output wire                    pslverr,
  output wire [31:0]             prdata,
  // Software writes to the data/command port.
  input  wire                    dataCmdWriteStb,
  input  wire [15:0]             dataCmdWriteData,
  // Master engine events.
  input  wire                    mstStartAttempt,
  input  wire                    mstCmdIssue,
  input  wire                    mstArbLost,
  input  wire                    mstAckSlot,
  input  wire [`TAC_PH_W-1:0]    mstAckPhase,
  input  wire                    mstAckReceived,
  // Slave engine events and levels.
  input  wire                    slvDataRequest,
  input  wire                    slvTxActive,
  input  wire                    slvReadCmdRx,
  input  wire                    txFifoNotEmpty,
  input  wire                    sclRise,
  input  wire                    sdaSample,
  input  wire                    sdaIntended,
  // Results.
  output wire [`TAC_REG_W-1:0]   abortCause,
  output wire                    transmitAbortInterrupt,
  output wire                    txFifoFlush,
  output wire                    masterModeEnable,
  output wire                    repeatedStartEnable
);

  reg  [`TAC_REG_W-1:0] cause_ff;
  reg  [`TAC_REG_W-1:0] control_ff;
  reg  [31:0]           prdata_ff;
  reg                   flush_ff;
  reg                   sbyteReassert_ff;
  reg  [`TAC_REG_W-1:0] setVec;
  reg  [31:0]           nxt_prdata;
  wire                  setupPhase;
  wire                  accessPhase;
  wire                  hitCause;
  wire                  hitControl;
  wire                  hitClear;
  wire                  mapped;
  wire                  writeControl;
  wire                  clearReq;
  wire                  tenBitMode;
  wire                  highSpeedMode;
  wire                  commandSelectA;
  wire                  generalCallOrStartSelect;
  wire                  startByteSelected;
  wire                  generalCallSelected;
  wire                  sbyteCause;
  wire                  slaveReadCmdWrite;
  wire                  slaveBusLost;
  wire                  staleTxFlush;
  wire                  ackPhaseHit;

  // The slave answers every transfer in its first access cycle.
  assign setupPhase   = psel & ~penable;
  assign accessPhase  = psel & penable;
  assign hitCause     = (paddr == `TAC_ADDR_ABORT_CAUSE);
  assign hitControl   = (paddr == `TAC_ADDR_CONTROL);
  assign hitClear     = (paddr == `TAC_ADDR_ABORT_CLEAR);
  assign mapped       = hitCause | hitControl | hitClear;
  assign pready       = 1'b1;
  // Writes to the read-only cause register are refused like unmapped ones.
  assign pslverr      = accessPhase & (~mapped | (pwrite & hitCause));
  assign prdata       = prdata_ff;
  assign writeControl = accessPhase & pwrite & hitControl;
  assign clearReq     = accessPhase & pwrite & hitClear & pwdata[`TAC_CLR_BIT];

  // Read data is captured in the setup cycle so it is a flip-flop output.
  always @* begin
    nxt_prdata = 32'h00000000;
    if (setupPhase & ~pwrite) begin
      if (hitCause) begin
        nxt_prdata[`TAC_REG_W-1:0] = cause_ff;
      end else if (hitControl) begin
        nxt_prdata[`TAC_REG_W-1:0] = control_ff;
      end
    end
  end

  assign masterModeEnable         = control_ff[`TAC_CTL_MASTER_ENABLE];
  assign repeatedStartEnable      = control_ff[`TAC_CTL_REPEATED_START_ENABLE];
  assign tenBitMode               = control_ff[`TAC_CTL_TEN_BIT_ADDR];
  assign highSpeedMode            = control_ff[`TAC_CTL_HIGH_SPEED];
  assign commandSelectA           = control_ff[`TAC_CTL_COMMAND_SELECT_A];
  assign generalCallOrStartSelect = control_ff[`TAC_CTL_GENERAL_CALL_OR_START];
  assign startByteSelected        = commandSelectA & generalCallOrStartSelect;
  assign generalCallSelected      = commandSelectA & ~generalCallOrStartSelect;

  // The START byte cause persists as long as this configuration stands.
  assign sbyteCause = ~repeatedStartEnable & startByteSelected;

  assign slaveReadCmdWrite = slvDataRequest & dataCmdWriteStb
                           & dataCmdWriteData[`TAC_DCP_CMD_BIT];
  // A mismatch at a clock rise means another party drives the data line.
  assign slaveBusLost = slvTxActive & sclRise & (sdaSample != sdaIntended);
  assign staleTxFlush = slvReadCmdRx & txFifoNotEmpty;
  assign ackPhaseHit  = mstAckSlot & masterModeEnable;

  always @* begin
    setVec = `TAC_CAUSE_RESET;
    setVec[`TAC_SLAVE_READ_CMD_WRITE_ERR] = slaveReadCmdWrite;
    setVec[`TAC_SLAVE_BUS_LOST]           = slaveBusLost;
    setVec[`TAC_SLAVE_STALE_TX_FLUSH]     = staleTxFlush;
    // Master and slave losses land in one shared bit.
    setVec[`TAC_ARBITRATION_LOST]         = mstArbLost | slaveBusLost;
    setVec[`TAC_MASTER_DISABLED_ATTEMPT]  = mstStartAttempt & ~masterModeEnable;
    setVec[`TAC_TEN_BIT_READ_NO_RESTART]  = mstCmdIssue & tenBitMode
                                          & dataCmdWriteData[`TAC_DCP_READ_BIT]
                                          & ~repeatedStartEnable;
    setVec[`TAC_START_BYTE_NO_RESTART]    = (mstCmdIssue & sbyteCause)
                                          | sbyteReassert_ff;
    setVec[`TAC_HIGH_SPEED_NO_RESTART]    = mstCmdIssue & highSpeedMode
                                          & ~repeatedStartEnable;
    setVec[`TAC_START_BYTE_ACKED]         = ackPhaseHit & mstAckReceived
                                          & (mstAckPhase == `TAC_PH_START_BYTE);
    setVec[`TAC_HIGH_SPEED_CODE_ACKED]    = ackPhaseHit & mstAckReceived
                                          & (mstAckPhase == `TAC_PH_HS_CODE);
    setVec[`TAC_GENERAL_CALL_READ_ERR]    = mstCmdIssue & generalCallSelected
                                          & dataCmdWriteData[`TAC_DCP_READ_BIT];
    setVec[`TAC_GENERAL_CALL_UNACKED]     = ackPhaseHit & ~mstAckReceived
                                          & (mstAckPhase == `TAC_PH_GENERAL_CALL);
    setVec[`TAC_DATA_BYTE_UNACKED]        = ackPhaseHit & ~mstAckReceived
                                          & (mstAckPhase == `TAC_PH_DATA);
    setVec[`TAC_TEN_BIT_ADDR_SECOND_UNACKED] = ackPhaseHit & ~mstAckReceived & tenBitMode
                                          & (mstAckPhase == `TAC_PH_ADDR10_SECOND);
    setVec[`TAC_TEN_BIT_ADDR_FIRST_UNACKED]  = ackPhaseHit & ~mstAckReceived & tenBitMode
                                          & (mstAckPhase == `TAC_PH_ADDR10_FIRST);
    setVec[`TAC_SEVEN_BIT_ADDR_UNACKED]   = ackPhaseHit & ~mstAckReceived & ~tenBitMode
                                          & (mstAckPhase == `TAC_PH_ADDR7);
  end

  // A set in the same cycle as the clear wins, so no event is lost.
  genvar gi;
  generate
    for (gi = 0; gi < `TAC_REG_W; gi = gi + 1) begin : g_flag
      always @(posedge clock or posedge reset) begin
        if (reset) begin
          cause_ff[gi] <= 1'b0;
        end else begin
          cause_ff[gi] <= setVec[gi] | (cause_ff[gi] & ~clearReq);
        end
      end
    end
  endgenerate

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      control_ff       <= `TAC_CONTROL_RESET;
      prdata_ff        <= 32'h00000000;
      flush_ff         <= 1'b0;
      sbyteReassert_ff <= 1'b0;
    end else begin
      prdata_ff <= nxt_prdata;
      flush_ff  <= staleTxFlush;
      // The cleared bit shows zero for exactly one cycle, then returns.
      sbyteReassert_ff <= clearReq & cause_ff[`TAC_START_BYTE_NO_RESTART]
                        & sbyteCause;
      if (writeControl) begin
        control_ff <= pwdata[`TAC_REG_W-1:0];
      end
    end
  end

  assign abortCause             = cause_ff;
  // The abort line stays up while any cause is recorded.
  assign transmitAbortInterrupt = |cause_ff;
  assign txFifoFlush            = flush_ff;

endmodule // tac_abort_tracker
`default_nettype wire

// ---- rtl/tac_defs.vh ----
// Constants for the transmit abort cause tracker: register addresses,
// field positions, reset values and acknowledge phase codes.
// Assumes inclusion by the tracker module and the bench; holds definitions only.
`ifndef TAC_DEFS_VH
`define TAC_DEFS_VH

// Register byte addresses on the APB bus.
`define TAC_ADDR_ABORT_CAUSE   32'h50001380
`define TAC_ADDR_CONTROL       32'h500013a0
`define TAC_ADDR_ABORT_CLEAR   32'h500013a4

// Widths and reset values.
`define TAC_REG_W              16
`define TAC_CAUSE_RESET        16'h0000
`define TAC_CONTROL_RESET      16'h0021

// Abort cause flag positions.
`define TAC_SEVEN_BIT_ADDR_UNACKED      0
`define TAC_TEN_BIT_ADDR_FIRST_UNACKED  1
`define TAC_TEN_BIT_ADDR_SECOND_UNACKED 2
`define TAC_DATA_BYTE_UNACKED           3
`define TAC_GENERAL_CALL_UNACKED        4
`define TAC_GENERAL_CALL_READ_ERR       5
`define TAC_HIGH_SPEED_CODE_ACKED       6
`define TAC_START_BYTE_ACKED            7
`define TAC_HIGH_SPEED_NO_RESTART       8
`define TAC_START_BYTE_NO_RESTART       9
`define TAC_TEN_BIT_READ_NO_RESTART     10
`define TAC_MASTER_DISABLED_ATTEMPT     11
`define TAC_ARBITRATION_LOST            12
`define TAC_SLAVE_STALE_TX_FLUSH        13
`define TAC_SLAVE_BUS_LOST              14
`define TAC_SLAVE_READ_CMD_WRITE_ERR    15

// Control register field positions.
`define TAC_CTL_MASTER_ENABLE           0
`define TAC_CTL_TEN_BIT_ADDR            1
`define TAC_CTL_HIGH_SPEED              2
`define TAC_CTL_REPEATED_START_ENABLE   5
`define TAC_CTL_GENERAL_CALL_OR_START   10
`define TAC_CTL_COMMAND_SELECT_A        11

// Abort clear register: writing a one here clears the cause flags.
`define TAC_CLR_BIT                     0

// Data/command port bit positions seen on a software write.
`define TAC_DCP_CMD_BIT                 8
`define TAC_DCP_READ_BIT                9

// Acknowledge slot phase codes from the master engine.
`define TAC_PH_W                3
`define TAC_PH_ADDR7            3'h0
`define TAC_PH_ADDR10_FIRST     3'h1
`define TAC_PH_ADDR10_SECOND    3'h2
`define TAC_PH_DATA             3'h3
`define TAC_PH_GENERAL_CALL     3'h4
`define TAC_PH_START_BYTE       3'h5
`define TAC_PH_HS_CODE          3'h6

`endif

// ---- dv/tac_abort_tracker_props.sv ----
// Checker for the abort cause tracker: timing of cause flags at its ports.
// Assumes a bind onto tac_abort_tracker, everything on one clock.
`timescale 1ns/1ns
`default_nettype none
module tac_abort_tracker_props (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic        dataCmdWriteStb,
  input wire logic [15:0] dataCmdWriteData,
  input wire logic        mstStartAttempt,
  input wire logic        mstArbLost,
  input wire logic        mstAckSlot,
  input wire logic [2:0]  mstAckPhase,
  input wire logic        mstAckReceived,
  input wire logic        slvDataRequest,
  input wire logic        slvTxActive,
  input wire logic        slvReadCmdRx,
  input wire logic        txFifoNotEmpty,
  input wire logic        sclRise,
  input wire logic        sdaSample,
  input wire logic        sdaIntended,
  input wire logic [15:0] abortCause,
  input wire logic        txFifoFlush,
  input wire logic        masterModeEnable
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  chk_slave_loss_pair: assert property (slvTxActive && sclRise && sdaSample != sdaIntended
    |=> abortCause[14] && abortCause[12]) else $error("slave bus loss not flagged");
  chk_loss_bits_together: assert property ($rose(abortCause[14]) |-> abortCause[12])
    else $error("slave loss without arbitration bit");
  chk_stale_flush: assert property (slvReadCmdRx && txFifoNotEmpty
    |=> abortCause[13] && txFifoFlush) else $error("stale fifo not flushed");
  chk_flush_cause: assert property (txFifoFlush
    |-> $past(slvReadCmdRx) && $past(txFifoNotEmpty)) else $error("flush without cause");
  chk_master_arb: assert property (mstArbLost |=> abortCause[12])
    else $error("arbitration loss not flagged");
  chk_master_off: assert property (mstStartAttempt && !masterModeEnable
    |=> abortCause[11]) else $error("disabled master attempt not flagged");
  chk_cmd_write_err: assert property (dataCmdWriteStb && dataCmdWriteData[8] && slvDataRequest
    |=> abortCause[15]) else $error("command write during slave read not flagged");
  chk_data_nack: assert property (mstAckSlot && masterModeEnable && mstAckPhase == 3'h3
    && !mstAckReceived |=> abortCause[3]) else $error("data nack not flagged");
  chk_flags_sticky: assert property (!(psel && penable && pwrite && paddr == 32'h500013a4)
    |=> (abortCause & $past(abortCause)) == $past(abortCause)) else $error("flag dropped");
  cover property (txFifoFlush);
  cover property (abortCause[14]);
  cover property (mstAckSlot && !mstAckReceived);
endmodule // tac_abort_tracker_props
`default_nettype wire

// ---- dv/tac_bus_peer.sv ----
// Remote bus party: echoes or spoils the data line and answers ack slots.
// Assumes the bench raises fault when the remote side should misbehave.
`timescale 1ns/1ns
`default_nettype none
module tac_bus_peer (
  input  wire logic fault,
  input  wire logic sdaDriven,
  output wire logic sdaSeen,
  output wire logic ackGiven
);
  // A remote driver pulling against us shows up as the inverse level.
  assign sdaSeen  = fault ? ~sdaDriven : sdaDriven;
  assign ackGiven = fault;
endmodule // tac_bus_peer
`default_nettype wire

// ---- dv/tb.sv ----
// Bench for the abort cause tracker: APB register access plus event pulses.
// Assumes the tracker, its defines header, the peer and the checker compile first.
`timescale 1ns/1ns
`default_nettype none
`include "tac_defs.vh"
module tb;
  logic        clock, reset, psel, penable, pwrite, sdaIntended, err;
  logic [31:0] paddr, pwdata, rd;
  logic [10:0] ev;
  logic [2:0]  ph;
  logic [15:0] dcw;
  wire         pready, pslverr, irq, flush, mEn, rsEn, sdaSeen, ackGiven;
  wire  [31:0] prdata;
  wire  [15:0] cause;
  int          n_fail, compares;
  tac_abort_tracker i_dut (.clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .prdata, .dataCmdWriteStb(ev[4]), .dataCmdWriteData(dcw), .mstStartAttempt(ev[0]),
    .mstCmdIssue(ev[1]), .mstArbLost(ev[2]), .mstAckSlot(ev[3]), .mstAckPhase(ph),
    .mstAckReceived(ackGiven), .slvDataRequest(ev[7]), .slvTxActive(ev[8]),
    .slvReadCmdRx(ev[5]), .txFifoNotEmpty(ev[9]), .sclRise(ev[6]), .sdaSample(sdaSeen),
    .sdaIntended, .abortCause(cause), .transmitAbortInterrupt(irq), .txFifoFlush(flush),
    .masterModeEnable(mEn), .repeatedStartEnable(rsEn));
  tac_bus_peer i_peer (.fault(ev[10]), .sdaDriven(sdaIntended), .sdaSeen, .ackGiven);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task end_of_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", nm, exp, got);
      n_fail++;
    end
  endtask
  task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int i;
    @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      n_fail++;
      end_of_test();
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Program control, pulse one cycle of events, then check pins and register view.
  task run(input logic [15:0] ctl, input logic [10:0] e, input logic [2:0] p,
           input logic [15:0] d, input logic [15:0] exp);
    apb(1'b1, `TAC_ADDR_CONTROL, {16'h0000, ctl});
    @(posedge clock);
    ev  <= e;
    ph  <= p;
    dcw <= d;
    @(posedge clock);
    ev  <= 11'h000;
    #1 chk("cause", {16'h0000, exp}, {16'h0000, cause});
    chk("flush", {31'h0, exp[13]}, {31'h0, flush});
    chk("irq", {31'h0, |exp}, {31'h0, irq});
    apb(1'b0, `TAC_ADDR_ABORT_CAUSE, 32'h0);
    chk("cause read", {16'h0000, exp}, rd);
    apb(1'b1, `TAC_ADDR_ABORT_CLEAR, 32'h1);
    $display("test done ctl %h events %h", ctl, e);
  endtask
  initial begin
    {reset, psel, penable, pwrite, sdaIntended} = 5'b10001;
    {paddr, pwdata, ev, ph, dcw, n_fail, compares} = '0;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    apb(1'b0, `TAC_ADDR_CONTROL, 32'h0);
    chk("control reset", 32'h00000021, rd);
    chk("master enable", 32'h1, {31'h0, mEn});
    chk("restart enable", 32'h1, {31'h0, rsEn});
    chk("pready", 32'h1, {31'h0, pready});
    apb(1'b1, `TAC_ADDR_ABORT_CAUSE, 32'h0000ffff);
    chk("cause write refused", 32'h1, {31'h0, err});
    apb(1'b0, `TAC_ADDR_ABORT_CAUSE, 32'h0);
    chk("cause reset", 32'h0, rd);
    apb(1'b0, 32'h500013fc, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    run(16'h0020, 11'h001, 3'h0, 16'h0000, 16'h0800);
    run(16'h0020, 11'h008, 3'h3, 16'h0000, 16'h0000);
    run(16'h0003, 11'h002, 3'h0, 16'h0200, 16'h0400);
    run(16'h0005, 11'h002, 3'h0, 16'h0000, 16'h0100);
    run(16'h0c21, 11'h408, 3'h5, 16'h0000, 16'h0080);
    run(16'h0025, 11'h408, 3'h6, 16'h0000, 16'h0040);
    run(16'h0821, 11'h002, 3'h0, 16'h0200, 16'h0020);
    run(16'h0821, 11'h008, 3'h4, 16'h0000, 16'h0010);
    run(16'h0021, 11'h008, 3'h3, 16'h0000, 16'h0008);
    run(16'h0023, 11'h008, 3'h2, 16'h0000, 16'h0004);
    run(16'h0023, 11'h008, 3'h1, 16'h0000, 16'h0002);
    run(16'h0021, 11'h008, 3'h0, 16'h0000, 16'h0001);
    run(16'h0023, 11'h008, 3'h0, 16'h0000, 16'h0000);
    run(16'h0021, 11'h004, 3'h0, 16'h0000, 16'h1000);
    run(16'h0021, 11'h090, 3'h0, 16'h0100, 16'h8000);
    run(16'h0021, 11'h010, 3'h0, 16'h0100, 16'h0000);
    run(16'h0021, 11'h540, 3'h0, 16'h0000, 16'h5000);
    run(16'h0021, 11'h140, 3'h0, 16'h0000, 16'h0000);
    run(16'h0021, 11'h220, 3'h0, 16'h0000, 16'h2000);
    run(16'h0021, 11'h020, 3'h0, 16'h0000, 16'h0000);
    run(16'h0021, 11'h094, 3'h0, 16'h0100, 16'h9000);
    run(16'h0c01, 11'h002, 3'h0, 16'h0000, 16'h0200);
    apb(1'b0, `TAC_ADDR_ABORT_CAUSE, 32'h0);
    chk("bit 9 back", 32'h00000200, rd);
    apb(1'b1, `TAC_ADDR_CONTROL, 32'h00000c21);
    apb(1'b1, `TAC_ADDR_ABORT_CLEAR, 32'h1);
    apb(1'b0, `TAC_ADDR_ABORT_CAUSE, 32'h0);
    chk("bit 9 cleared", 32'h0, rd);
    end_of_test();
  end
endmodule // tb
bind tac_abort_tracker tac_abort_tracker_props i_props (.clock, .reset, .psel, .penable, .pwrite,
  .paddr, .dataCmdWriteStb, .dataCmdWriteData, .mstStartAttempt, .mstArbLost, .mstAckSlot,
  .mstAckPhase, .mstAckReceived, .slvDataRequest, .slvTxActive, .slvReadCmdRx, .txFifoNotEmpty,
  .sclRise, .sdaSample, .sdaIntended, .abortCause, .txFifoFlush, .masterModeEnable);
`default_nettype wire
